/* File: hw/pfm_pkg.sv */
// Shared constants and types for the page, flag and move instruction unit.
// Assumes a 16-bit instruction word and 4-bit data paths of a small core.
package pfm_pkg;

	localparam int DATA_W     = 4;
	localparam int ADDR_W     = 7;
	localparam int WSEL_W     = 4;
	localparam int OP5_W      = 5;
	localparam int OP9_W      = OP5_W + WSEL_W;
	localparam int PAGE_PTR_W = 3;
	localparam int WAKE_W     = 8;
	localparam int MEM_DEPTH  = 128;

	// Opcode prefixes
	localparam logic [OP5_W-1:0] OP5_IND_STORE = 5'h1b;
	localparam logic [OP9_W-1:0] OP_PAGE_LOAD  = 9'h0bb;
	localparam logic [OP9_W-1:0] OP_CARRY_COPY = 9'h1c8;
	localparam logic [OP9_W-1:0] OP_WAKE_UPPER = 9'h093;
	localparam logic [OP9_W-1:0] OP_WAKE_LOWER = 9'h092;
	localparam logic [OP9_W-1:0] OP_PAGE_READ  = 9'h0bf;
	localparam logic [OP9_W-1:0] OP_PORT_C     = 9'h09d;
	localparam logic [OP9_W-1:0] OP_SERIAL     = 9'h0be;

	// Reset values and field layout
	localparam logic [DATA_W-1:0] PAGE_RESET   = 4'h0;
	localparam logic [DATA_W-1:0] ACC_RESET    = 4'h0;
	localparam logic [WAKE_W-1:0] WAKE_RESET   = 8'h00;
	localparam logic [WAKE_W-1:0] WAKE_MASK    = 8'hf7;
	localparam logic [ADDR_W-1:0] WR_BASE      = 7'h00;
	localparam int                WAKE_LO_LSB  = 0;
	localparam int                WAKE_HI_LSB  = 4;

	// Wake-cause bit positions
	localparam int WAKE_DIV0_OVF   = 0;
	localparam int WAKE_TMR0_UNF   = 1;
	localparam int WAKE_PORT_C_CHG = 2;
	localparam int WAKE_RESERVED   = 3;
	localparam int WAKE_EXT_FALL   = 4;
	localparam int WAKE_TMR1_UNF   = 5;
	localparam int WAKE_SER_RX     = 6;
	localparam int WAKE_SER_TX     = 7;

	typedef struct packed
	{
		logic [OP5_W-1:0]  op5;
		logic [WSEL_W-1:0] wsel;
		logic [ADDR_W-1:0] addr;
	} pfm_instr_s;

	typedef struct packed
	{
		logic [DATA_W-1:0] port_c_change_flags;
		logic [DATA_W-1:0] serial_status_flags;
	} pfm_status_s;

	typedef enum {PFM_IDLE, PFM_STORE} pfm_state_e;

endpackage

/* File: hw/pfm_move_unit.sv */
// Execution unit for paged stores, page register moves and flag-to-accumulator moves.
// Assumes issue, events and status come from logic on mclk; owns the 128x4 data memory.
`timescale 1ns/1ps

module pfm_move_unit #(
	parameter int MEM_DEPTH = pfm_pkg::MEM_DEPTH
) (
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	input  wire logic                        instr_valid,
	input  wire pfm_pkg::pfm_instr_s         instr,
	output logic                             instr_ready,
	output logic                             instr_done,
	input  wire logic                        carry_flag,
	input  wire logic [pfm_pkg::WAKE_W-1:0]  wake_event,
	input  wire logic                        wake_clear,
	input  wire pfm_pkg::pfm_status_s        status_in,
	output logic [pfm_pkg::DATA_W-1:0]       acc,
	output logic                             zero_flag,
	output logic [pfm_pkg::DATA_W-1:0]       page_reg,
	input  wire logic [pfm_pkg::ADDR_W-1:0]  dbg_addr,
	output logic [pfm_pkg::DATA_W-1:0]       dbg_rdata
);

	// Direct and paged addresses both span the whole array, so nothing else is served
	if (MEM_DEPTH != (1 << pfm_pkg::ADDR_W))
	begin : g_depth_check
		$error("MEM_DEPTH must equal the 7-bit address space");
	end

	logic [pfm_pkg::DATA_W-1:0] mem [MEM_DEPTH];

	pfm_pkg::pfm_state_e          state_r;
	pfm_pkg::pfm_state_e          state_nxt;
	logic [pfm_pkg::DATA_W-1:0]   acc_r;
	logic [pfm_pkg::DATA_W-1:0]   acc_nxt;
	logic                         zf_r;
	logic                         zf_nxt;
	logic [pfm_pkg::DATA_W-1:0]   page_r;
	logic [pfm_pkg::DATA_W-1:0]   page_nxt;
	logic [pfm_pkg::WAKE_W-1:0]   wake_r;
	logic [pfm_pkg::WAKE_W-1:0]   wake_nxt;
	logic [pfm_pkg::ADDR_W-1:0]   ptr_r;
	logic [pfm_pkg::ADDR_W-1:0]   ptr_nxt;
	logic [pfm_pkg::DATA_W-1:0]   hold_r;
	logic [pfm_pkg::DATA_W-1:0]   hold_nxt;
	logic                         done_r;
	logic                         done_nxt;
	logic [pfm_pkg::DATA_W-1:0]   dbg_r;
	logic [pfm_pkg::DATA_W-1:0]   dbg_nxt;
	logic                         mem_we;
	logic [pfm_pkg::ADDR_W-1:0]   mem_waddr;
	logic [pfm_pkg::DATA_W-1:0]   mem_wdata;
	logic [pfm_pkg::OP9_W-1:0]    op9;
	logic [pfm_pkg::DATA_W-1:0]   move_and_acc_load_val;
	logic                         move_and_acc_load_hit;
	logic [pfm_pkg::DATA_W-1:0]   rdata;
	logic [pfm_pkg::DATA_W-1:0]   wr_data;

	assign op9         = {instr.op5, instr.wsel};
	assign rdata       = mem[instr.addr];
	assign wr_data     = mem[pfm_pkg::WR_BASE | {3'h0, instr.wsel}];
	assign instr_ready = (state_r == pfm_pkg::PFM_IDLE);
	assign instr_done  = done_r;
	assign acc         = acc_r;
	assign zero_flag   = zf_r;
	assign page_reg    = page_r;
	assign dbg_rdata   = dbg_r;

	// Source selection for the accumulator-and-word moves
	always_comb
	begin
		move_and_acc_load_val = 4'h0;
		move_and_acc_load_hit = 1'b1;
		case (op9)
			pfm_pkg::OP_CARRY_COPY: move_and_acc_load_val = {3'h0, carry_flag};
			pfm_pkg::OP_WAKE_UPPER: move_and_acc_load_val = wake_r[pfm_pkg::WAKE_HI_LSB +: 4];
			pfm_pkg::OP_WAKE_LOWER: move_and_acc_load_val = wake_r[pfm_pkg::WAKE_LO_LSB +: 4];
			pfm_pkg::OP_PAGE_READ:  move_and_acc_load_val = page_r;
			pfm_pkg::OP_PORT_C:     move_and_acc_load_val = status_in.port_c_change_flags;
			pfm_pkg::OP_SERIAL:     move_and_acc_load_val = status_in.serial_status_flags;
			default:                move_and_acc_load_hit = 1'b0;
		endcase
	end

	always_comb
	begin
		state_nxt = state_r;
		acc_nxt   = acc_r;
		zf_nxt    = zf_r;
		page_nxt  = page_r;
		ptr_nxt   = ptr_r;
		hold_nxt  = hold_r;
		done_nxt  = 1'b0;
		mem_we    = 1'b0;
		mem_waddr = '0;
		mem_wdata = '0;
		dbg_nxt   = mem[dbg_addr];
		// Set beats clear so an event in the clearing cycle survives; reads never clear
		wake_nxt  = ((wake_clear ? pfm_pkg::WAKE_RESET : wake_r) | wake_event)
			& pfm_pkg::WAKE_MASK;
		case (state_r)
			pfm_pkg::PFM_IDLE:
			begin
				if (instr_valid)
				begin
					if (instr.op5 == pfm_pkg::OP5_IND_STORE)
					begin
						// Pointer and source captured now; write lands next cycle
						ptr_nxt   = {page_r[pfm_pkg::PAGE_PTR_W-1:0], rdata};
						hold_nxt  = wr_data;
						state_nxt = pfm_pkg::PFM_STORE;
					end
					else if (op9 == pfm_pkg::OP_PAGE_LOAD)
					begin
						page_nxt = rdata;
						done_nxt = 1'b1;
					end
					else if (move_and_acc_load_hit)
					begin
						acc_nxt   = move_and_acc_load_val;
						zf_nxt    = (move_and_acc_load_val == 4'h0);
						mem_we    = 1'b1;
						mem_waddr = instr.addr;
						mem_wdata = move_and_acc_load_val;
						done_nxt  = 1'b1;
					end
					else
					begin
						// Foreign opcodes belong to other units
						done_nxt = 1'b0;
					end
				end
			end
			pfm_pkg::PFM_STORE:
			begin
				mem_we    = 1'b1;
				mem_waddr = ptr_r;
				mem_wdata = hold_r;
				done_nxt  = 1'b1;
				state_nxt = pfm_pkg::PFM_IDLE;
			end
			default:
			begin
				state_nxt = pfm_pkg::PFM_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			state_r <= pfm_pkg::PFM_IDLE;
			acc_r   <= pfm_pkg::ACC_RESET;
			zf_r    <= 1'b0;
			page_r  <= pfm_pkg::PAGE_RESET;
			wake_r  <= pfm_pkg::WAKE_RESET;
			ptr_r   <= '0;
			hold_r  <= '0;
			done_r  <= 1'b0;
			dbg_r   <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			acc_r   <= acc_nxt;
			zf_r    <= zf_nxt;
			page_r  <= page_nxt;
			wake_r  <= wake_nxt;
			ptr_r   <= ptr_nxt;
			hold_r  <= hold_nxt;
			done_r  <= done_nxt;
			dbg_r   <= dbg_nxt;
		end
	end

	// Memory contents are not reset, as in a plain RAM
	always_ff @(posedge mclk)
	begin
		if (mem_we)
			mem[mem_waddr] <= mem_wdata;
	end

endmodule

/* File: verif/pfm_move_unit_monitor.sv */
// Checker for pfm_move_unit results and issue timing.
// Bound to each pfm_move_unit; sees its ports only.
`timescale 1ns/1ps
module pfm_move_unit_monitor (
	input wire logic                       mclk,
	input wire logic                       rst_n,
	input wire logic                       instr_valid,
	input wire pfm_pkg::pfm_instr_s        instr,
	input wire logic                       instr_ready,
	input wire logic                       instr_done,
	input wire logic                       carry_flag,
	input wire logic [pfm_pkg::WAKE_W-1:0] wake_event,
	input wire pfm_pkg::pfm_status_s       status_in,
	input wire logic [pfm_pkg::DATA_W-1:0] acc,
	input wire logic                       zero_flag,
	input wire logic [pfm_pkg::DATA_W-1:0] page_reg
);
	wire [8:0] c = {instr.op5, instr.wsel};
	wire       t = instr_valid && instr_ready;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	carry_copy_a: assert property (t && c == pfm_pkg::OP_CARRY_COPY |=>
		acc == {3'h0, $past(carry_flag)} && zero_flag == !$past(carry_flag)) else $error("carry");
	page_read_a: assert property (t && c == pfm_pkg::OP_PAGE_READ |=>
		acc == $past(page_reg) && zero_flag == ($past(page_reg) == 4'h0)) else $error("page");
	port_chg_a: assert property (t && c == pfm_pkg::OP_PORT_C |=>
		acc == $past(status_in.port_c_change_flags) && instr_done) else $error("port c");
	serial_stat_a: assert property (t && c == pfm_pkg::OP_SERIAL |=>
		acc == $past(status_in.serial_status_flags)
		&& zero_flag == ($past(status_in.serial_status_flags) == 4'h0)) else $error("ser");
	page_load_a: assert property (t && c == pfm_pkg::OP_PAGE_LOAD |=>
		instr_done && $stable(acc)) else $error("page load");
	ind_store_a: assert property (t && instr.op5 == pfm_pkg::OP5_IND_STORE |=>
		!instr_ready && !instr_done ##1 instr_ready && instr_done) else $error("store");
	wake_high_a: assert property (t && c == pfm_pkg::OP_WAKE_UPPER && $past(rst_n) |=>
		(acc & $past(wake_event[7:4], 2)) == $past(wake_event[7:4], 2)) else $error("wake hi");
	wake_low_a: assert property (t && c == pfm_pkg::OP_WAKE_LOWER && $past(rst_n) |=>
		!acc[3] && (acc[2:0] & $past(wake_event[2:0], 2)) == $past(wake_event[2:0], 2))
		else $error("wake lo");
endmodule
bind pfm_move_unit pfm_move_unit_monitor u_pfm_move_unit_monitor (.*);

/* File: verif/pfm_move_unit_tb_top.sv */
// Bench for pfm_move_unit: flag move table, then page, store and wake cases.
// Inputs change at the falling edge of a 40 MHz clock, except instr_valid, which drops at the rising edge.
`timescale 1ns/1ps
module pfm_move_unit_tb_top;
	typedef struct packed
	{
		logic [8:0] c;
		logic       cf;
		logic [7:0] st;
		logic [3:0] e;
	} pfm_row_s;
	logic                 mclk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 instr_valid = 1'b0;
	pfm_pkg::pfm_instr_s  instr = '0;
	logic                 carry_flag = 1'b0;
	logic [7:0]           wake_event = 8'h00;
	logic                 wake_clear = 1'b0;
	pfm_pkg::pfm_status_s status_in = '0;
	logic [6:0]           dbg_addr = 7'h00;
	logic                 instr_ready, instr_done, zero_flag;
	logic [3:0]           acc, page_reg, dbg_rdata;
	int                   failures = 0, tests_run = 0, cycles = 0;
	pfm_row_s             rows [6] = '{'{pfm_pkg::OP_CARRY_COPY, 1'b1, 8'h00, 4'h1},
		'{pfm_pkg::OP_CARRY_COPY, 1'b0, 8'hff, 4'h0}, '{pfm_pkg::OP_PORT_C, 1'b0, 8'ha5, 4'ha},
		'{pfm_pkg::OP_SERIAL, 1'b1, 8'ha5, 4'h5}, '{pfm_pkg::OP_SERIAL, 1'b0, 8'hf0, 4'h0},
		'{pfm_pkg::OP_WAKE_LOWER, 1'b1, 8'hff, 4'h0}};
	pfm_move_unit u_pfm_move_unit (.*);
	initial
	begin
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			end_of_test();
		end
	end
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Valid drops on the take edge so back-to-back issues never rewrite it in one step
	task automatic op(input logic [8:0] c, input logic [6:0] a);
		instr_valid = 1'b1;
		instr = {c, a};
		@(posedge mclk);
		instr_valid <= 1'b0;
		@(negedge mclk);
	endtask
	task automatic peek(input logic [6:0] a, input logic [3:0] e);
		dbg_addr = a;
		@(negedge mclk);
		chk(dbg_rdata, e);
	endtask
	// Memory has no reset, so words are seeded through the port C status move
	task automatic put(input logic [6:0] a, input logic [3:0] v);
		status_in = {v, 4'h0};
		op(pfm_pkg::OP_PORT_C, a);
	endtask
	task automatic end_of_test();
		$display("checks=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(negedge mclk);
		chk({instr_ready, zero_flag, page_reg, acc}, 12'h200);
		rst_n = 1'b1;
		foreach (rows[i])
		begin
			carry_flag = rows[i].cf;
			status_in = rows[i].st;
			op(rows[i].c, 7'h20 + 7'(i));
			chk({zero_flag, acc}, {rows[i].e == 4'h0, rows[i].e});
			peek(7'h20 + 7'(i), rows[i].e);
		end
		put(7'h30, 4'hd);
		op(pfm_pkg::OP_PAGE_LOAD, 7'h30);
		chk({instr_done, page_reg}, 12'h01d);
		op(pfm_pkg::OP_PAGE_READ, 7'h32);
		chk({zero_flag, acc}, 12'h00d);
		peek(7'h32, 4'hd);
		put(7'h03, 4'h9);
		put(7'h31, 4'h4);
		op({pfm_pkg::OP5_IND_STORE, 4'h3}, 7'h31);
		chk({instr_ready, instr_done}, 12'h000);
		@(negedge mclk);
		chk({instr_ready, instr_done}, 12'h003);
		peek(7'h54, 4'h9);
		wake_event = 8'hff;
		@(negedge mclk);
		wake_event = 8'h00;
		op(pfm_pkg::OP_WAKE_UPPER, 7'h40);
		chk(acc, 12'h00f);
		op(pfm_pkg::OP_WAKE_LOWER, 7'h41);
		chk(acc, 12'h007);
		op(pfm_pkg::OP_WAKE_UPPER, 7'h42);
		chk(acc, 12'h00f);
		wake_clear = 1'b1;
		@(negedge mclk);
		wake_clear = 1'b0;
		op(pfm_pkg::OP_WAKE_LOWER, 7'h43);
		chk({zero_flag, acc}, 12'h010);
		wake_clear = 1'b1;
		wake_event = 8'h21;
		@(negedge mclk);
		wake_clear = 1'b0;
		wake_event = 8'h00;
		op(pfm_pkg::OP_WAKE_LOWER, 7'h44);
		chk({zero_flag, acc}, 12'h001);
		op(pfm_pkg::OP_WAKE_UPPER, 7'h45);
		chk({zero_flag, acc}, 12'h002);
		end_of_test();
	end
endmodule
